// ---- pmu_pkg.sv ----
package pmu_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] OFS_POWER_CONFIG      = 8'h87;
  localparam logic [7:0] OFS_EXT_IRQ_ENABLE    = 8'hE5;
  localparam logic [7:0] OFS_EXT_IRQ_EDGE_SEL  = 8'hE6;
  localparam logic [7:0] OFS_EXT_IRQ_FLAGS     = 8'hE7;
  localparam logic [7:0] OFS_PERIPH_CLK_GATES  = 8'hFE;
  localparam logic [7:0] OFS_SYS_CTRL_MISC     = 8'hFF;
  localparam logic [7:0] OFS_CLOCK_SYS_CTRL    = 8'hFA;
  // ==========================================
  // reset values
  localparam logic [7:0] RST_POWER_CONFIG      = 8'h00;
  localparam logic [7:0] RST_EXT_IRQ_ENABLE    = 8'h00;
  localparam logic [7:0] RST_EXT_IRQ_EDGE_SEL  = 8'h00;
  localparam logic [7:0] RST_EXT_IRQ_FLAGS     = 8'h00;
  localparam logic [7:0] RST_PERIPH_CLK_GATES  = 8'hC4;
  localparam logic [7:0] RST_SYS_CTRL_MISC     = 8'hC2;
  localparam logic [7:0] RST_CLOCK_SYS_CTRL    = 8'h00;
  // ==========================================
  // field positions
  localparam int BIT_BAUD_DOUBLE_A   = 7;
  localparam int BIT_BAUD_DOUBLE_B   = 6;
  localparam int BIT_FLASH_WR_PERMIT = 4;
  localparam int BIT_STOP            = 1;
  localparam int BIT_FILTER_SEL_LO   = 6;
  localparam int BIT_TIMER_CLK       = 7;
  localparam int BIT_MULDIV_CLK      = 5;
  localparam int BIT_SPI_CLK         = 3;
  localparam int BIT_UART_CLK        = 2;
  localparam int BIT_I2C_CLK         = 1;
  localparam int BIT_ADC_CLK         = 0;
  localparam int BIT_UART_IF_EN      = 5;
  localparam int BIT_TIMER01_DIV_SEL = 4;
  localparam int BIT_ADDR_RST_EN     = 2;
  localparam int BIT_WATCHDOG_CLK    = 1;
  localparam int BIT_PLL_EN          = 0;
  localparam int NUM_SRC             = 6;
  localparam int NUM_PINS            = 4;
  localparam logic [7:0] MASK_SRC    = 8'h3F;
  localparam logic [7:0] MASK_POWER_CONFIG   = 8'hD2;
  localparam logic [7:0] MASK_GATES  = 8'hAF;
  localparam logic [7:0] MASK_MISC   = 8'h36;
  localparam logic [7:0] MASK_CLKSYS = 8'h01;
  // ==========================================
  // debounce lengths in clock cycles
  localparam logic [7:0] FILT_LEN_0  = 8'h04;
  localparam logic [7:0] FILT_LEN_1  = 8'h25;
  localparam logic [7:0] FILT_LEN_2  = 8'h48;
  localparam logic [7:0] FILT_LEN_3  = 8'h8E;
  // ==========================================
  // power states
  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_SLEEP = 2'b10
  } pwr_state_t;
endpackage : pmu_pkg

// ---- wake_filter.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// one input: three-stage sync, debounce, edge detect
module wake_filter (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       raw_in,
  input  wire logic [7:0] filt_len,
  input  wire logic       rise_sel,
  output logic            edge_pulse
);
  logic [2:0] sync_q;
  logic       stable_q;
  logic       seen_q;
  logic [7:0] cnt_q;

  // synchroniser chain; stage 0 feeds stage 1 only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1], sync_q[0], raw_in};
    end
  end

  // debounce: level must hold filt_len cycles
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q    <= 8'h00;
      stable_q <= 1'b0;
      seen_q   <= 1'b0;
    end else begin
      if (sync_q[2] != sync_q[1] || sync_q[2] == stable_q) begin
        cnt_q <= 8'h00;
      end else if (cnt_q + 8'h01 >= filt_len) begin
        cnt_q    <= 8'h00;
        stable_q <= sync_q[2];
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
      seen_q <= stable_q;
    end
  end

  // selected edge of the filtered level
  assign edge_pulse = rise_sel ? (stable_q & ~seen_q) : (~stable_q & seen_q);
endmodule // wake_filter
`default_nettype wire

// ---- sleep_wakeup_clock_gating.sv ----
`timescale 1ns/10ps
`default_nettype none
// Function
// - writing stop bit gates system clock and holds the core
// - only external lines zero to three wake the device
// - clocked sources such as watchdog and serial stay silent in sleep
// - wake restarts clock; core fetches vector of waking source
// - after return, code continues after the sleeping instruction
// - normal: core clock runs, peripherals follow gates; sleep: all off
// - filter length select bits 7:6 choose 4, 37, 72 or 142 cycles
// - enable bits 0..3 gate the four pin sources
// - enable bits 4 and 5 gate comparator up and down
// - edge bits 5:0: zero falling, one rising
// - flags set by events, cleared by writing zero
// - flash write permit bit 4 allows writes during data moves
// - bits 7 and 6 double uart baud rate
// - gate register bits enable timer, muldiv, spi, uart, i2c, adc
// - misc bit 5 enables the uart interface
// - timer clock divided by 8, 2, 4 or 1 per mode pair
// - clock system bit 0 enables the pll
// - misc bit 2 enables address overrange reset
// - misc bit 1 gates the watchdog clock
module sleep_wakeup_clock_gating
  import pmu_pkg::*;
(
  input  wire logic                  REF_CLK,
  input  wire logic                  ARST_N,
  input  wire logic [7:0]            ADDR,
  input  wire logic [7:0]            WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic      [7:0]            RDATA,
  input  wire logic [NUM_PINS-1:0]   WAKE_PINS,
  input  wire logic                  CMP_UP,
  input  wire logic                  CMP_DOWN,
  input  wire logic                  TIMER_ZERO_MODE_BIT,
  output logic                       CPU_CLK_EN,
  output logic                       CPU_HOLD,
  output logic                       TIMER_CLK_GATE,
  output logic                       MULDIV_CLK_GATE,
  output logic                       SPI_CLK_GATE,
  output logic                       UART_CLK_GATE,
  output logic                       I2C_CLK_GATE,
  output logic                       ADC_CLK_GATE,
  output logic                       WATCHDOG_CLK_GATE,
  output logic                       TIMER01_TICK,
  output logic                       FLASH_WRITE_PERMIT,
  output logic                       BAUD_DOUBLE_A,
  output logic                       BAUD_DOUBLE_B,
  output logic                       UART_IF_ENABLE,
  output logic                       ADDR_OVERRANGE_RESET_ENABLE,
  output logic                       PLL_ENABLE,
  output logic      [NUM_SRC-1:0]    IRQ_REQ,
  output logic                       WAKE_EVENT
);
  import pmu_pkg::*;

  logic [7:0]         power_config_q;
  logic [7:0]         en_q;
  logic [7:0]         edge_q;
  logic [7:0]         flags_q;
  logic [7:0]         gates_q;
  logic [7:0]         misc_q;
  logic [7:0]         clksys_q;
  logic [7:0]         rdata_q;
  logic [7:0]         filt_len;
  logic [NUM_SRC-1:0] raw_src;
  logic [NUM_SRC-1:0] edge_ev;
  logic [NUM_SRC-1:0] src_ev;
  logic [NUM_SRC-1:0] wake_ev;
  logic [2:0]         div_q;
  logic               div_tick;
  logic               flag_wr;
  pwr_state_t         state_q;
  pwr_state_t         state_d;

  // ==========================================
  // wake inputs
  assign raw_src = {CMP_DOWN, CMP_UP, WAKE_PINS};

  // filter length select
  always_comb begin
    unique case (en_q[BIT_FILTER_SEL_LO +: 2])
      2'b00:   filt_len = FILT_LEN_0;
      2'b01:   filt_len = FILT_LEN_1;
      2'b10:   filt_len = FILT_LEN_2;
      default: filt_len = FILT_LEN_3;
    endcase
  end

  // one filter per source
  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      wake_filter u_filt (
        .clk        (REF_CLK),
        .arst_n     (ARST_N),
        .raw_in     (raw_src[i]),
        .filt_len   (filt_len),
        .rise_sel   (edge_q[i]),
        .edge_pulse (edge_ev[i])
      );
    end
  endgenerate

  // enabled events; in sleep only pin lines count
  assign src_ev  = edge_ev & en_q[NUM_SRC-1:0];
  assign wake_ev = src_ev & {{(NUM_SRC-NUM_PINS){1'b0}}, {NUM_PINS{1'b1}}};
  assign WAKE_EVENT = (state_q == ST_SLEEP) && (|wake_ev);
  assign IRQ_REQ = flags_q[NUM_SRC-1:0];

  // ==========================================
  // power state machine
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN: begin
        if (power_config_q[BIT_STOP]) state_d = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (|wake_ev) state_d = ST_RUN;
      end
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // core and peripheral clock enables
  assign CPU_CLK_EN = (state_q == ST_RUN) && !power_config_q[BIT_STOP];
  assign CPU_HOLD   = !CPU_CLK_EN;
  assign TIMER_CLK_GATE    = CPU_CLK_EN & gates_q[BIT_TIMER_CLK];
  assign MULDIV_CLK_GATE   = CPU_CLK_EN & gates_q[BIT_MULDIV_CLK];
  assign SPI_CLK_GATE      = CPU_CLK_EN & gates_q[BIT_SPI_CLK];
  assign UART_CLK_GATE     = CPU_CLK_EN & gates_q[BIT_UART_CLK];
  assign I2C_CLK_GATE      = CPU_CLK_EN & gates_q[BIT_I2C_CLK];
  assign ADC_CLK_GATE      = CPU_CLK_EN & gates_q[BIT_ADC_CLK];
  assign WATCHDOG_CLK_GATE = CPU_CLK_EN & misc_q[BIT_WATCHDOG_CLK];

  // static control outputs
  assign FLASH_WRITE_PERMIT = power_config_q[BIT_FLASH_WR_PERMIT];
  assign BAUD_DOUBLE_A      = power_config_q[BIT_BAUD_DOUBLE_A];
  assign BAUD_DOUBLE_B      = power_config_q[BIT_BAUD_DOUBLE_B];
  assign UART_IF_ENABLE     = misc_q[BIT_UART_IF_EN];
  assign ADDR_OVERRANGE_RESET_ENABLE = misc_q[BIT_ADDR_RST_EN];
  assign PLL_ENABLE         = clksys_q[BIT_PLL_EN];

  // ==========================================
  // timer0/1 clock divider
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_q <= 3'h0;
    end else if (CPU_CLK_EN) begin
      div_q <= div_q + 3'h1;
    end
  end

  always_comb begin
    unique case ({TIMER_ZERO_MODE_BIT, misc_q[BIT_TIMER01_DIV_SEL]})
      2'b00:   div_tick = (div_q == 3'h7);
      2'b01:   div_tick = div_q[0];
      2'b10:   div_tick = (div_q[1:0] == 2'h3);
      default: div_tick = 1'b1;
    endcase
  end

  assign TIMER01_TICK = div_tick & TIMER_CLK_GATE;

  // ==========================================
  // register writes
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      power_config_q <= RST_POWER_CONFIG;
    end else if (WR && ADDR == OFS_POWER_CONFIG) begin
      power_config_q <= WDATA & MASK_POWER_CONFIG;
    end else if (state_q == ST_SLEEP && (|wake_ev)) begin
      power_config_q[BIT_STOP] <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      en_q   <= RST_EXT_IRQ_ENABLE;
      edge_q <= RST_EXT_IRQ_EDGE_SEL;
    end else if (WR) begin
      if (ADDR == OFS_EXT_IRQ_ENABLE) en_q <= WDATA;
      if (ADDR == OFS_EXT_IRQ_EDGE_SEL) edge_q <= WDATA & MASK_SRC;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      gates_q  <= RST_PERIPH_CLK_GATES;
      misc_q   <= RST_SYS_CTRL_MISC;
      clksys_q <= RST_CLOCK_SYS_CTRL;
    end else if (WR) begin
      if (ADDR == OFS_PERIPH_CLK_GATES) gates_q <= WDATA;
      if (ADDR == OFS_SYS_CTRL_MISC) misc_q <= WDATA;
      if (ADDR == OFS_CLOCK_SYS_CTRL) clksys_q <= WDATA & MASK_CLKSYS;
    end
  end

  // flags: set wins over write-zero clear
  assign flag_wr = WR && (ADDR == OFS_EXT_IRQ_FLAGS);

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flags_q <= RST_EXT_IRQ_FLAGS;
    end else begin
      flags_q <= ((flag_wr ? (flags_q & WDATA) : flags_q)
                  | {2'b00, src_ev}) & MASK_SRC;
    end
  end

  // ==========================================
  // read data, one cycle after strobe
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= 8'h00;
    end else if (RD) begin
      unique case (ADDR)
        OFS_POWER_CONFIG:     rdata_q <= power_config_q;
        OFS_EXT_IRQ_ENABLE:   rdata_q <= en_q;
        OFS_EXT_IRQ_EDGE_SEL: rdata_q <= edge_q;
        OFS_EXT_IRQ_FLAGS:    rdata_q <= flags_q;
        OFS_PERIPH_CLK_GATES: rdata_q <= gates_q & MASK_GATES | (gates_q & ~MASK_GATES);
        OFS_SYS_CTRL_MISC:    rdata_q <= misc_q;
        OFS_CLOCK_SYS_CTRL:   rdata_q <= clksys_q;
        default:              rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign RDATA = rdata_q;
endmodule // sleep_wakeup_clock_gating
`default_nettype wire

// ---- pin_stim.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// wake pins and comparators, each change bounces once
module pin_stim (
  input  wire logic       clk,
  input  wire logic [5:0] lvl,
  output logic      [3:0] pins,
  output logic            cmp_up,
  output logic            cmp_down
);
  logic [5:0] prev_q = 6'h00;
  logic [5:0] bnc_q  = 6'h00;
  // remember level, flag a fresh change
  always_ff @(posedge clk) begin
    prev_q <= lvl;
    bnc_q  <= lvl ^ prev_q;
  end
  // new level, old level for a cycle, then new again
  assign {cmp_down, cmp_up, pins} = lvl ^ bnc_q;
endmodule // pin_stim
`default_nettype wire

// ---- pmu_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// port checks of the power block
module pmu_checker
  import pmu_pkg::*;
(
  input wire logic                       REF_CLK,
  input wire logic                       ARST_N,
  input wire logic [7:0]                 ADDR,
  input wire logic [7:0]                 WDATA,
  input wire logic                       WR,
  input wire logic                       CPU_CLK_EN,
  input wire logic                       CPU_HOLD,
  input wire logic                       TIMER_CLK_GATE,
  input wire logic                       ADC_CLK_GATE,
  input wire logic                       WATCHDOG_CLK_GATE,
  input wire logic                       FLASH_WRITE_PERMIT,
  input wire logic                       PLL_ENABLE,
  input wire logic [pmu_pkg::NUM_SRC-1:0] IRQ_REQ,
  input wire logic                       WAKE_EVENT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  a_stop_sleeps: assert property (WR && ADDR == OFS_POWER_CONFIG && WDATA[BIT_STOP]
    |=> !CPU_CLK_EN && CPU_HOLD) else $error("stop write did not halt");
  a_hold_mirror: assert property (CPU_HOLD == !CPU_CLK_EN)
    else $error("hold not inverse of clock enable");
  a_sleep_gates: assert property (!CPU_CLK_EN
    |-> !(TIMER_CLK_GATE || ADC_CLK_GATE || WATCHDOG_CLK_GATE)) else $error("gate on in sleep");
  a_wake_restart: assert property (WAKE_EVENT |=> CPU_CLK_EN [*2])
    else $error("clock not restarted by wake");
  a_wake_flag: assert property (WAKE_EVENT |=> (|IRQ_REQ[3:0]))
    else $error("wake without pin flag");
  a_exit_cause: assert property ($rose(CPU_CLK_EN) |-> $past(WAKE_EVENT))
    else $error("sleep left without pin wake");
  a_pll_write: assert property ($changed(PLL_ENABLE) |-> $past(WR)
    && $past(ADDR) == OFS_CLOCK_SYS_CTRL) else $error("pll enable moved alone");
  a_flash_write: assert property ($changed(FLASH_WRITE_PERMIT) |-> $past(WR)
    && $past(ADDR) == OFS_POWER_CONFIG) else $error("flash permit moved alone");
endmodule // pmu_checker
bind sleep_wakeup_clock_gating pmu_checker CHK (.REF_CLK, .ARST_N, .ADDR, .WDATA, .WR,
  .CPU_CLK_EN, .CPU_HOLD, .TIMER_CLK_GATE, .ADC_CLK_GATE, .WATCHDOG_CLK_GATE,
  .FLASH_WRITE_PERMIT, .PLL_ENABLE, .IRQ_REQ, .WAKE_EVENT);
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pmu_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, tmode = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, s;
  logic [5:0] lvl = 6'h00, irq;
  logic [6:0] gates;
  logic [3:0] pins;
  logic       cup, cdn, clk_en, hold, wake, tick, fwp, bda, bdb, uif, aor, pll, e;
  int         err_count = 0, samples_checked = 0, cyc = 0, n, k, m[int];
  int         fl[4] = '{4, 37, 72, 142};
  int         dv[4] = '{8, 2, 4, 1};
  logic [7:0] al[8] = '{8'h87, 8'hE5, 8'hE6, 8'hE7, 8'hFE, 8'hFF, 8'hFA, 8'h80};
  sleep_wakeup_clock_gating DUT (.REF_CLK(clk), .ARST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .WAKE_PINS(pins), .CMP_UP(cup), .CMP_DOWN(cdn),
    .TIMER_ZERO_MODE_BIT(tmode), .CPU_CLK_EN(clk_en), .CPU_HOLD(hold),
    .TIMER_CLK_GATE(gates[6]), .MULDIV_CLK_GATE(gates[5]), .SPI_CLK_GATE(gates[4]),
    .UART_CLK_GATE(gates[3]), .I2C_CLK_GATE(gates[2]), .ADC_CLK_GATE(gates[1]),
    .WATCHDOG_CLK_GATE(gates[0]), .TIMER01_TICK(tick), .FLASH_WRITE_PERMIT(fwp),
    .BAUD_DOUBLE_A(bda), .BAUD_DOUBLE_B(bdb), .UART_IF_ENABLE(uif),
    .ADDR_OVERRANGE_RESET_ENABLE(aor), .PLL_ENABLE(pll), .IRQ_REQ(irq), .WAKE_EVENT(wake));
  pin_stim PS (.clk(clk), .lvl(lvl), .pins(pins), .cmp_up(cup), .cmp_down(cdn));
  // ==========================================
  // clock and hang guard
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  // ==========================================
  // bus tasks and model
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("reg", rdata, m.exists(a) ? 8'(m[a]) : 8'h00);
    @(posedge clk);
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] v);
    wr_reg(a, v);
    case (a)
      8'h87: m[a] = v & MASK_POWER_CONFIG;
      8'hE6: m[a] = v & MASK_SRC;
      8'hE7: m[a] = m[a] & v;
      8'hFA: m[a] = v & MASK_CLKSYS;
      default: if (m.exists(a)) m[a] = v;
    endcase
  endtask
  task automatic outs();
    logic [7:0] g, c, p, x;
    g = m[8'hFE];
    c = m[8'hFF];
    p = m[8'h87];
    x = m[8'hFA];
    chk("gates", {1'b0, gates}, {1'b0, g[7], g[5], g[3:0], c[1]});
    chk("levels", {2'b0, fwp, bda, bdb, uif, aor, pll}, {2'b0, p[4], p[7:6], c[5], c[2], x[0]});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h2208));
    m = '{8'h87: 0, 8'hE5: 0, 8'hE6: 0, 8'hE7: 0, 8'hFE: 8'hC4, 8'hFF: 8'hC2, 8'hFA: 0};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (al[x]) rchk(al[x]);
    outs();
    $display("test reset done");
    repeat (4) foreach (al[x]) begin
      d = $urandom;
      d[1] = d[1] & (al[x] != 8'h87);
      put(al[x], d);
      rchk(al[x]);
      outs();
    end
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      e = 1'($urandom);
      put(8'hE5, 8'h00);
      lvl[i] <= ~e;
      lvl[4] <= 1'b0;
      repeat (170) @(posedge clk);
      put(8'hE7, 8'h00);
      put(8'hE6, 8'h10 | (8'(e) << i));
      put(8'hE5, {2'(i), 6'h10} | (8'h01 << i));
      wr_reg(8'h87, 8'(m[8'h87]) | 8'h02);
      chk("asleep", {6'h00, clk_en, hold}, 8'h01);
      chk("gates_off", {1'b0, gates}, 8'h00);
      lvl[4] <= 1'b1;
      repeat (170) @(posedge clk);
      chk("cmp_no_wake", {7'h00, clk_en}, 8'h00);
      lvl[i] <= e;
      n = 0;
      while (clk_en !== 1'b1 && n < 400) begin
        @(posedge clk);
        n++;
      end
      chk("wake_time", {7'h00, n >= fl[i] && n <= fl[i] + 12}, 8'h01);
      m[8'hE7] = 32'h10 | (1 << i);
      chk("irq", {2'b00, irq}, 8'(m[8'hE7]));
      rchk(8'h87);
      put(8'hE7, ~(8'h01 << i));
      rchk(8'hE7);
    end
    $display("test sleep done");
    // timer ticks need the timer clock gate, which random writes may have cleared
    put(8'hFE, 8'(m[8'hFE]) | 8'h80);
    for (int j = 0; j < 4; j++) begin
      tmode <= j[1];
      s = m[8'hFF];
      s[4] = j[0];
      put(8'hFF, s);
      k = 0;
      repeat (64) begin
        @(posedge clk);
        k += tick;
      end
      chk("tick", 8'(k), 8'(64 / dv[j]));
    end
    $display("test timer done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
